/* File: lbc_pkg.sv */
// Purpose: shared constants and types of the bank command logic
// Assumes: link clock period as in the bench, four banks
// Notes: times are kept in ns, the link period in ps; cycle counts are derived and rounded up
package lbc_pkg;
    localparam int LINK_PERIOD_PS = 15000;
    localparam int ADDR_W = 14;
    localparam int BANKS = 4;
    localparam int TMR_W = 8;
    // time figures in ns
    localparam int ACT_TO_ACCESS_NS = 18;
    localparam int PRECHARGE_NS = 18;
    localparam int WRITE_RECOVERY_NS = 15;
    localparam int MODE_LOAD_DELAY_NS = 10;
    localparam int PD_EXIT_NS = 8;
    localparam int SR_EXIT_NS = 120;
    // derived cycle counts, least times round up
    localparam int ACT_TO_ACCESS_CYC =
        (ACT_TO_ACCESS_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int PRECHARGE_CYC =
        (PRECHARGE_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int WRITE_RECOVERY_CYC =
        (WRITE_RECOVERY_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int MODE_LOAD_DELAY_CYC =
        (MODE_LOAD_DELAY_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int PD_EXIT_CYC =
        (PD_EXIT_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    localparam int SR_EXIT_CYC =
        (SR_EXIT_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    // mode register fields and reset value
    localparam int MODE_BL_LSB = 0;
    localparam int MODE_CL_LSB = 4;
    localparam logic [13:0] MODE_RESET = 14'h0032;
    localparam logic [13:0] EXT_MODE_RESET = 14'h0000;
    localparam int AP_BIT = 10;
    localparam logic [1:0] EXT_MODE_BANK = 2'h2;
    localparam logic [2:0] CL_TWO = 3'h2;
    localparam int READ_PIPE_DEPTH = 3;

    typedef enum logic [2:0] {
        LBC_CMD_NOP = 3'b000,
        LBC_CMD_ACT = 3'b001,
        LBC_CMD_RD = 3'b010,
        LBC_CMD_WR = 3'b011,
        LBC_CMD_PRE = 3'b100,
        LBC_CMD_REF = 3'b101,
        LBC_CMD_MODE = 3'b110,
        LBC_CMD_BST = 3'b111
    } lbc_cmd_t;

    typedef enum logic [2:0] {
        LBC_IDLE = 3'b000,
        LBC_ACTIVATING = 3'b001,
        LBC_ACTIVE = 3'b010,
        LBC_READ = 3'b011,
        LBC_WRITE = 3'b100,
        LBC_READ_AP = 3'b101,
        LBC_WRITE_AP = 3'b110,
        LBC_PRECHARGING = 3'b111
    } lbc_bank_st_t;

    typedef struct packed {
        logic cke;
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bank_select_bits;
        logic [ADDR_W-1:0] addr;
    } lbc_cmd_pins_t;

    typedef struct packed {
        logic [BANKS-1:0] bank_open;
        logic read_busy;
        logic powered_down;
    } lbc_status_t;
endpackage

/* File: lbc_sync2.sv */
// Purpose: two flip-flop synchroniser for levels
// Assumes: rst_n is synchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module lbc_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // lbc_sync2

/* File: lbc_bank_cmd.sv */
// Purpose: command acceptance, bank states and read bursts of the memory
// Assumes: pins are synchronous to link_clk; clk_sys only reads status and mode registers
// Notes: read data is a fixed pattern of bank and column
// Functional notes
// R1: chip select high registers nothing
// R2: nop behaves exactly like deselect
// R3: commands need cke twice high, exit time
// R4: idle bank accepts any command; the code accepts only active there, read and write need an open row
// R5: other banks accept active, read, write, precharge
// R6: other-bank read during burst starts new burst
// R7: auto-precharge access period limits other banks
// R8: read auto-precharge precharges after burst pairs
// R9: write auto-precharge precharges after write recovery
// R10: controller avoids read and write data contention
// R11: refresh and mode load only all idle
// R12: burst terminate acts on current read bank
// R13: write after read needs completion or terminate
// R14: interrupted write data masked by controller
// R15: mode load all idle, then wait delay
// R16: active opens row; access needs open row
// R17: controller waits activate delay before access
// R18: same-bank activates spaced, row closed first
// R19: cross-bank activates spaced by interval
// R20: row stays open until precharge
// R21: read bursts burst length, optional auto-precharge
// R22: strobe preamble, edge-aligned data, postamble; CL 2/3
// R23: data lines released after final burst
// R24: inputs sampled on rising true clock edge
`timescale 1ns/1ps
module lbc_bank_cmd #(
    parameter int DQ_W = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire lbc_pkg::lbc_cmd_pins_t cmd_pins,
    input wire logic [DQ_W/8-1:0] data_mask,
    input wire logic [DQ_W-1:0] dq_i,
    output logic [DQ_W-1:0] dq_o,
    output logic dq_oe,
    input wire logic dqs_i,
    output logic dqs_o,
    output logic dqs_oe,
    output lbc_pkg::lbc_status_t status_sys,
    output logic [lbc_pkg::ADDR_W-1:0] mode_reg_sys,
    output logic [lbc_pkg::ADDR_W-1:0] ext_mode_reg_sys
);
    localparam int BN = lbc_pkg::BANKS;
    localparam int AW = lbc_pkg::ADDR_W;
    localparam int TW = lbc_pkg::TMR_W;
    localparam int PD = lbc_pkg::READ_PIPE_DEPTH;

    logic lrst_n;
    lbc_pkg::lbc_cmd_pins_t pins_reg;
    logic cke_prev_reg;
    logic pd_reg;
    logic sr_reg;
    logic [TW-1:0] exit_cnt_reg;
    logic [TW-1:0] mode_cnt_reg;
    logic [AW-1:0] mode_reg;
    logic [AW-1:0] ext_mode_reg;
    logic mode_tgl_reg;
    lbc_pkg::lbc_bank_st_t st_reg [BN];
    logic [TW-1:0] tmr_reg [BN];
    logic [AW-1:0] row_reg [BN];
    logic [PD-1:0] rp_valid_reg;
    logic [PD-1:0] rp_term_reg;
    logic [1:0] rp_bank_reg [PD];
    logic [AW-1:0] rp_col_reg [PD];
    logic [1:0] rd_bank_reg;
    logic [1:0] burst_bank_reg;
    logic burst_reg;
    logic post_reg;
    logic [3:0] pair_cnt_reg;
    logic [AW-1:0] col_reg;
    logic [DQ_W-1:0] word0_reg;
    logic [DQ_W-1:0] word1_reg;
    lbc_pkg::lbc_cmd_t cmd;
    logic cmd_live;
    logic all_idle;
    logic [1:0] tb;
    logic ap;
    logic acc_act;
    logic acc_rd;
    logic acc_wr;
    logic acc_pre;
    logic acc_mode;
    logic acc_bst;
    logic [3:0] bl_pairs;
    logic cl_two;
    logic start_burst;
    logic term_burst;
    logic preamble;
    logic [AW-1:0] start_col;

    lbc_sync2 #(.W(1)) u_rst_sync (
        .clk(link_clk),
        .rst_n(1'b1),
        .d(rst_n),
        .q(lrst_n)
    );

    function automatic logic [DQ_W-1:0] pattern(input logic [1:0] b,
                                                input logic [AW-1:0] c);
        logic [DQ_W+AW+1:0] full;
        full = {{DQ_W{1'b0}}, b, c};
        return full[DQ_W-1:0];
    endfunction

    function automatic logic is_open_st(input lbc_pkg::lbc_bank_st_t s);
        return s == lbc_pkg::LBC_ACTIVE || s == lbc_pkg::LBC_READ
            || s == lbc_pkg::LBC_WRITE;
    endfunction

    // pins taken on the rising edge of the true clock
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            pins_reg <= '1;
            cke_prev_reg <= 1'b0;
        end else begin
            pins_reg <= cmd_pins; // see R24
            cke_prev_reg <= pins_reg.cke;
        end
    end

    always_comb begin
        case ({pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n})
            3'b011: cmd = lbc_pkg::LBC_CMD_ACT;
            3'b101: cmd = lbc_pkg::LBC_CMD_RD;
            3'b100: cmd = lbc_pkg::LBC_CMD_WR;
            3'b010: cmd = lbc_pkg::LBC_CMD_PRE;
            3'b001: cmd = lbc_pkg::LBC_CMD_REF;
            3'b000: cmd = lbc_pkg::LBC_CMD_MODE;
            3'b110: cmd = lbc_pkg::LBC_CMD_BST;
            default: cmd = lbc_pkg::LBC_CMD_NOP; // see R2
        endcase
    end

    assign all_idle = st_reg[0] == lbc_pkg::LBC_IDLE
        && st_reg[1] == lbc_pkg::LBC_IDLE && st_reg[2] == lbc_pkg::LBC_IDLE
        && st_reg[3] == lbc_pkg::LBC_IDLE;
    // deselect and low cke register nothing; exit and mode delays block
    assign cmd_live = !pins_reg.cs_n && cke_prev_reg && pins_reg.cke
        && exit_cnt_reg == '0 && mode_cnt_reg == '0; // see R1, R3, R15
    assign tb = pins_reg.bank_select_bits;
    assign ap = pins_reg.addr[lbc_pkg::AP_BIT];
    assign acc_act = cmd_live && cmd == lbc_pkg::LBC_CMD_ACT
        && st_reg[tb] == lbc_pkg::LBC_IDLE; // see R4, R20
    assign acc_rd = cmd_live && cmd == lbc_pkg::LBC_CMD_RD
        && is_open_st(st_reg[tb]); // see R5, R6, R16
    assign acc_wr = cmd_live && cmd == lbc_pkg::LBC_CMD_WR
        && is_open_st(st_reg[tb]); // see R5, R16
    assign acc_pre = cmd_live && cmd == lbc_pkg::LBC_CMD_PRE;
    assign acc_mode = cmd_live && cmd == lbc_pkg::LBC_CMD_MODE && all_idle
        && !burst_reg && rp_valid_reg == '0; // see R15
    assign acc_bst = cmd_live && cmd == lbc_pkg::LBC_CMD_BST
        && st_reg[rd_bank_reg] == lbc_pkg::LBC_READ; // see R12

    always_comb begin
        case (mode_reg[lbc_pkg::MODE_BL_LSB +: 3])
            3'h1: bl_pairs = 4'h1;
            3'h2: bl_pairs = 4'h2;
            3'h3: bl_pairs = 4'h4;
            default: bl_pairs = 4'h8;
        endcase
    end
    assign cl_two = mode_reg[lbc_pkg::MODE_CL_LSB +: 3] == lbc_pkg::CL_TWO;

    // power-down, self-refresh and exit timing
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            pd_reg <= 1'b0;
            sr_reg <= 1'b0;
            exit_cnt_reg <= '0;
        end else if (cke_prev_reg && !pins_reg.cke) begin
            pd_reg <= 1'b1;
            sr_reg <= !pins_reg.cs_n && cmd == lbc_pkg::LBC_CMD_REF
                && all_idle;
        end else if (!cke_prev_reg && pins_reg.cke && pd_reg) begin
            pd_reg <= 1'b0;
            sr_reg <= 1'b0;
            exit_cnt_reg <= sr_reg ? TW'(lbc_pkg::SR_EXIT_CYC)
                : TW'(lbc_pkg::PD_EXIT_CYC); // see R3
        end else if (exit_cnt_reg != '0) begin
            exit_cnt_reg <= exit_cnt_reg - 1'b1;
        end
    end

    // mode register loading
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            mode_reg <= lbc_pkg::MODE_RESET;
            ext_mode_reg <= lbc_pkg::EXT_MODE_RESET;
            mode_cnt_reg <= '0;
            mode_tgl_reg <= 1'b0;
        end else if (acc_mode) begin
            if (tb == lbc_pkg::EXT_MODE_BANK) begin
                ext_mode_reg <= pins_reg.addr;
            end else begin
                mode_reg <= pins_reg.addr;
            end
            mode_cnt_reg <= TW'(lbc_pkg::MODE_LOAD_DELAY_CYC); // see R15
            mode_tgl_reg <= !mode_tgl_reg;
        end else if (mode_cnt_reg != '0) begin
            mode_cnt_reg <= mode_cnt_reg - 1'b1;
        end
    end

    // per-bank state machines
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            for (int i = 0; i < BN; i++) begin
                st_reg[i] <= lbc_pkg::LBC_IDLE;
                tmr_reg[i] <= '0;
                row_reg[i] <= '0;
            end
        end else begin
            for (int i = 0; i < BN; i++) begin
                if (tmr_reg[i] != '0) begin
                    tmr_reg[i] <= tmr_reg[i] - 1'b1;
                end
                case (st_reg[i])
                    lbc_pkg::LBC_ACTIVATING,
                    lbc_pkg::LBC_READ,
                    lbc_pkg::LBC_WRITE: begin
                        if (tmr_reg[i] <= TW'(1)) begin
                            st_reg[i] <= lbc_pkg::LBC_ACTIVE;
                        end
                    end
                    lbc_pkg::LBC_READ_AP,
                    lbc_pkg::LBC_WRITE_AP: begin
                        if (tmr_reg[i] <= TW'(1)) begin
                            st_reg[i] <= lbc_pkg::LBC_PRECHARGING;
                            tmr_reg[i] <= TW'(lbc_pkg::PRECHARGE_CYC);
                        end
                    end
                    lbc_pkg::LBC_PRECHARGING: begin
                        if (tmr_reg[i] <= TW'(1)) begin
                            st_reg[i] <= lbc_pkg::LBC_IDLE;
                        end
                    end
                    default: begin
                    end
                endcase
                // bank-targeted commands; other banks run on untouched unless a precharge with ap set closes them or a burst terminate stops the read bank
                if (acc_act && tb == 2'(i)) begin
                    st_reg[i] <= lbc_pkg::LBC_ACTIVATING; // see R16
                    row_reg[i] <= pins_reg.addr;
                    tmr_reg[i] <= TW'(lbc_pkg::ACT_TO_ACCESS_CYC);
                end else if (acc_rd && tb == 2'(i)) begin
                    st_reg[i] <= ap ? lbc_pkg::LBC_READ_AP
                        : lbc_pkg::LBC_READ; // see R21
                    tmr_reg[i] <= TW'(bl_pairs); // see R8
                end else if (acc_wr && tb == 2'(i)) begin
                    st_reg[i] <= ap ? lbc_pkg::LBC_WRITE_AP
                        : lbc_pkg::LBC_WRITE;
                    tmr_reg[i] <= ap ? TW'(bl_pairs) + TW'(1)
                        + TW'(lbc_pkg::WRITE_RECOVERY_CYC)
                        : TW'(bl_pairs) + TW'(1); // see R9
                end else if (acc_pre && (ap || tb == 2'(i))
                             && is_open_st(st_reg[i])) begin
                    st_reg[i] <= lbc_pkg::LBC_PRECHARGING; // see R20
                    tmr_reg[i] <= TW'(lbc_pkg::PRECHARGE_CYC);
                end else if (acc_bst && rd_bank_reg == 2'(i)) begin
                    st_reg[i] <= lbc_pkg::LBC_ACTIVE; // see R12
                    tmr_reg[i] <= '0;
                end
            end
        end
    end

    // read launch pipeline, tapped at the CAS latency
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            rp_valid_reg <= '0;
            rp_term_reg <= '0;
            rd_bank_reg <= '0;
            for (int k = 0; k < PD; k++) begin
                rp_bank_reg[k] <= '0;
                rp_col_reg[k] <= '0;
            end
        end else begin
            rp_valid_reg <= {rp_valid_reg[PD-2:0], acc_rd};
            rp_term_reg <= {rp_term_reg[PD-2:0], acc_bst};
            rp_bank_reg[0] <= tb;
            rp_col_reg[0] <= pins_reg.addr;
            for (int k = 1; k < PD; k++) begin
                rp_bank_reg[k] <= rp_bank_reg[k-1];
                rp_col_reg[k] <= rp_col_reg[k-1];
            end
            if (acc_rd) begin
                rd_bank_reg <= tb; // see R12
            end
        end
    end

    assign start_burst = cl_two ? rp_valid_reg[0] : rp_valid_reg[1];
    assign term_burst = cl_two ? rp_term_reg[0] : rp_term_reg[1];
    assign start_col = cl_two ? rp_col_reg[0] : rp_col_reg[1];
    assign preamble = !burst_reg
        && (cl_two ? acc_rd : rp_valid_reg[0]); // see R22

    // burst engine: a newer read restarts, terminate cuts it short
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            burst_reg <= 1'b0;
            post_reg <= 1'b0;
            pair_cnt_reg <= '0;
            col_reg <= '0;
            burst_bank_reg <= '0;
            word0_reg <= '0;
            word1_reg <= '0;
        end else if (start_burst) begin
            burst_reg <= 1'b1; // see R6, R21
            post_reg <= 1'b0;
            pair_cnt_reg <= bl_pairs - 1'b1;
            col_reg <= start_col;
            // a later read to another bank must not rename this burst
            burst_bank_reg <= cl_two ? rp_bank_reg[0] : rp_bank_reg[1];
            word0_reg <= pattern(cl_two ? rp_bank_reg[0] : rp_bank_reg[1],
                                 start_col);
            word1_reg <= pattern(cl_two ? rp_bank_reg[0] : rp_bank_reg[1],
                                 start_col + 1'b1);
        end else if (burst_reg && (term_burst || pair_cnt_reg == '0)) begin
            burst_reg <= 1'b0; // see R23
            post_reg <= 1'b1; // see R22
        end else if (burst_reg) begin
            pair_cnt_reg <= pair_cnt_reg - 1'b1;
            col_reg <= col_reg + AW'(2);
            word0_reg <= pattern(burst_bank_reg, col_reg + AW'(2));
            word1_reg <= pattern(burst_bank_reg, col_reg + AW'(3));
        end else begin
            post_reg <= 1'b0;
        end
    end

    logic pre_reg;
    always_ff @(posedge link_clk) begin
        if (!lrst_n) begin
            pre_reg <= 1'b0;
        end else begin
            pre_reg <= preamble;
        end
    end

    // data edge-aligned with the strobe: first word while the clock is high
    assign dq_o = link_clk ? word0_reg : word1_reg; // see R22
    assign dq_oe = burst_reg; // see R23
    assign dqs_o = link_clk & burst_reg;
    assign dqs_oe = pre_reg | burst_reg | post_reg; // see R22

    // status towards the system clock
    lbc_pkg::lbc_status_t status_link;
    always_comb begin
        for (int i = 0; i < BN; i++) begin
            status_link.bank_open[i] = st_reg[i] != lbc_pkg::LBC_IDLE
                && st_reg[i] != lbc_pkg::LBC_PRECHARGING;
        end
        status_link.read_busy = burst_reg | (rp_valid_reg != '0);
        status_link.powered_down = pd_reg;
    end

    lbc_sync2 #(.W($bits(lbc_pkg::lbc_status_t))) u_status_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d(status_link),
        .q(status_sys)
    );

    // mode word is stable long after the toggle, so capture on its change
    logic mode_tgl_sys;
    logic mode_tgl_seen_reg;
    lbc_sync2 #(.W(1)) u_mode_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .d(mode_tgl_reg),
        .q(mode_tgl_sys)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mode_tgl_seen_reg <= 1'b0;
            mode_reg_sys <= lbc_pkg::MODE_RESET;
            ext_mode_reg_sys <= lbc_pkg::EXT_MODE_RESET;
        end else begin
            mode_tgl_seen_reg <= mode_tgl_sys;
            if (mode_tgl_sys != mode_tgl_seen_reg) begin
                mode_reg_sys <= mode_reg;
                ext_mode_reg_sys <= ext_mode_reg;
            end
        end
    end
endmodule // lbc_bank_cmd

/* File: lbc_bank_cmd_checker.sv */
// Purpose: port assertions for the bank command block
// Assumes: commands sampled on link_clk rise, walk timing of the block
// Notes: bound to every lbc_bank_cmd instance
`timescale 1ns/1ps
module lbc_bank_cmd_checker (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire lbc_pkg::lbc_cmd_pins_t cmd_pins,
    input wire logic dq_oe,
    input wire logic dqs_o,
    input wire logic dqs_oe,
    input wire logic [lbc_pkg::ADDR_W-1:0] mode_reg_sys,
    input wire logic [lbc_pkg::ADDR_W-1:0] ext_mode_reg_sys
);
    logic rd_sel;
    logic [3:0] idle_reg;
    assign rd_sel = cmd_pins.cke && !cmd_pins.cs_n && cmd_pins.ras_n
        && !cmd_pins.cas_n && cmd_pins.we_n;
    // link cycles since the last selected read, saturating
    always_ff @(posedge link_clk) begin
        if (!rst_n || rd_sel) begin
            idle_reg <= 4'h0;
        end else if (idle_reg != 4'hF) begin
            idle_reg <= idle_reg + 4'h1;
        end
    end
    sequence s_no_rd;
        (!rd_sel)[*4];
    endsequence
    sequence s_post;
        dqs_oe && !dqs_o ##1 !dqs_oe;
    endsequence
    a_data_strobe: assert property (
        @(posedge link_clk) disable iff (!rst_n) dq_oe |-> dqs_oe)
        else $error("data driven without strobe");
    a_preamble_low: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        $rose(dqs_oe) |-> !dq_oe && !dqs_o ##1 dq_oe)
        else $error("preamble not one low cycle");
    a_read_cause: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        $rose(dqs_oe) |-> $past(rd_sel, 2) || $past(rd_sel, 3))
        else $error("strobe without selected read");
    a_quiet_desel: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        s_no_rd |=> !$rose(dqs_oe))
        else $error("burst started with no read");
    a_postamble_end: assert property (
        @(posedge link_clk) disable iff (!rst_n) $fell(dq_oe) |-> s_post)
        else $error("postamble or release wrong");
    a_burst_end: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        idle_reg > 4'hB |-> !dq_oe && !dqs_oe)
        else $error("lines driven after last burst");
    a_data_latency: assert property (
        @(posedge link_clk) disable iff (!rst_n)
        $rose(dq_oe) |-> $past(rd_sel, 3) || $past(rd_sel, 4))
        else $error("data not at cas latency");
    a_mode_reset: assert property (
        @(posedge clk_sys) disable iff (!rst_n) $rose(rst_n) |->
        mode_reg_sys == lbc_pkg::MODE_RESET
        && ext_mode_reg_sys == lbc_pkg::EXT_MODE_RESET)
        else $error("mode registers not at reset value");
endmodule // lbc_bank_cmd_checker

bind lbc_bank_cmd lbc_bank_cmd_checker i_lbc_bank_cmd_checker (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .link_clk(link_clk),
    .cmd_pins(cmd_pins),
    .dq_oe(dq_oe),
    .dqs_o(dqs_o),
    .dqs_oe(dqs_oe),
    .mode_reg_sys(mode_reg_sys),
    .ext_mode_reg_sys(ext_mode_reg_sys)
);

/* File: lbc_host_model.sv */
// Purpose: memory controller model driving command pins
// Assumes: callers space commands by the timing counts
// Notes: issues no writes, so data lines are never contended
`timescale 1ns/1ps
module lbc_host_model (
    input wire logic link_clk,
    output lbc_pkg::lbc_cmd_pins_t cmd_pins,
    output logic [1:0] data_mask,
    output logic [15:0] dq_i,
    output logic dqs_i
);
    initial begin
        cmd_pins = {1'b1, 1'b1, 3'h7, 2'h0, 14'h0000};
        data_mask = 2'h3;
        dq_i = 16'hA5A5;
        dqs_i = 1'b0;
    end
    // undriven data lines change every cycle
    always @(negedge link_clk) begin
        dq_i <= ~dq_i;
        dqs_i <= ~dqs_i;
    end
    task automatic drive(input lbc_pkg::lbc_cmd_t c, input logic [1:0] b,
        input logic [13:0] a, input logic cs_n, input logic cke);
        logic [2:0] e;
        case (c)
            lbc_pkg::LBC_CMD_ACT: e = 3'h3;
            lbc_pkg::LBC_CMD_RD: e = 3'h5;
            lbc_pkg::LBC_CMD_WR: e = 3'h4;
            lbc_pkg::LBC_CMD_PRE: e = 3'h2;
            lbc_pkg::LBC_CMD_REF: e = 3'h1;
            lbc_pkg::LBC_CMD_MODE: e = 3'h0;
            lbc_pkg::LBC_CMD_BST: e = 3'h6;
            default: e = 3'h7;
        endcase
        @(negedge link_clk);
        cmd_pins <= {cke, cs_n, e, b, a};
    endtask
    task automatic issue(input lbc_pkg::lbc_cmd_t c, input logic [1:0] b,
        input logic [13:0] a, input logic cs_n);
        drive(c, b, a, cs_n, 1'b1);
        drive(lbc_pkg::LBC_CMD_NOP, 2'h0, 14'h0000, 1'b0, 1'b1);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge link_clk);
    endtask
endmodule // lbc_host_model

/* File: lbc_bank_cmd_tb.sv */
// Purpose: self-checking bench for the bank command block
// Assumes: reset mode is burst of four, cas latency three
// Notes: read words are bank and column, column then column plus one
`timescale 1ns/1ps
module lbc_bank_cmd_tb;
    logic clk_sys;
    logic link_clk;
    logic rst_n;
    lbc_pkg::lbc_cmd_pins_t cmd_pins;
    logic [1:0] data_mask;
    logic [15:0] dq_i;
    logic [15:0] dq_o;
    logic dq_oe;
    logic dqs_i;
    logic dqs_o;
    logic dqs_oe;
    lbc_pkg::lbc_status_t status_sys;
    logic [13:0] mode_reg_sys;
    logic [13:0] ext_mode_reg_sys;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    lbc_bank_cmd i_lbc_bank_cmd (.clk_sys(clk_sys), .rst_n(rst_n),
        .link_clk(link_clk), .cmd_pins(cmd_pins), .data_mask(data_mask),
        .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_i(dqs_i),
        .dqs_o(dqs_o), .dqs_oe(dqs_oe), .status_sys(status_sys),
        .mode_reg_sys(mode_reg_sys), .ext_mode_reg_sys(ext_mode_reg_sys));
    lbc_host_model i_lbc_host_model (.link_clk(link_clk),
        .cmd_pins(cmd_pins), .data_mask(data_mask), .dq_i(dq_i),
        .dqs_i(dqs_i));
    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmd(input lbc_pkg::lbc_cmd_t c, input logic [1:0] b,
        input logic [13:0] a);
        i_lbc_host_model.issue(c, b, a, 1'b0);
    endtask
    // lead counts link edges from return of the read to first data
    task automatic burst(input logic [1:0] b, input logic [13:0] c,
        input int lead, input int pairs);
        repeat (lead - 1) @(posedge link_clk);
        if (lead > 1) begin
            #1 chk({dqs_oe, dq_oe}, 20'h2);
        end
        for (int i = 0; i < pairs; i++) begin
            @(posedge link_clk);
            #1 chk({dq_oe, dq_o}, {1'b1, b, c + 14'(2 * i)});
            @(negedge link_clk);
            #1 chk(dq_o, {b, c + 14'(2 * i + 1)});
        end
    endtask
    task automatic post();
        @(posedge link_clk);
        #1 chk({dqs_oe, dq_oe, dqs_o}, 20'h4);
        @(posedge link_clk);
        #1 chk(dqs_oe, 20'h0);
    endtask
    task automatic quiet(input int n);
        repeat (n) @(posedge link_clk);
        #1 chk({dq_oe, dqs_oe}, 20'h0);
    endtask
    task automatic wait_open(input logic [3:0] exp);
        for (int n = 0; n < 40 && status_sys.bank_open !== exp; n++) begin
            @(negedge clk_sys);
        end
        chk(status_sys.bank_open, exp);
    endtask
    task automatic t_read_basic();
        cmd(lbc_pkg::LBC_CMD_ACT, 2'h0, 14'h0123);
        wait_open(4'h1);
        i_lbc_host_model.idle(lbc_pkg::ACT_TO_ACCESS_CYC);
        cmd(lbc_pkg::LBC_CMD_RD, 2'h0, 14'h0004);
        burst(2'h0, 14'h0004, 3, 2);
        post();
    endtask
    task automatic t_desel();
        i_lbc_host_model.issue(lbc_pkg::LBC_CMD_RD, 2'h0, 14'h0004, 1'b1);
        cmd(lbc_pkg::LBC_CMD_NOP, 2'h0, 14'h0000);
        quiet(6);
    endtask
    task automatic t_interleave();
        cmd(lbc_pkg::LBC_CMD_ACT, 2'h1, 14'h0200);
        wait_open(4'h3);
        i_lbc_host_model.idle(lbc_pkg::ACT_TO_ACCESS_CYC);
        cmd(lbc_pkg::LBC_CMD_RD, 2'h1, 14'h0010);
        cmd(lbc_pkg::LBC_CMD_RD, 2'h0, 14'h0020);
        burst(2'h1, 14'h0010, 1, 2);
        burst(2'h0, 14'h0020, 1, 2);
        post();
    endtask
    task automatic t_power();
        i_lbc_host_model.drive(lbc_pkg::LBC_CMD_NOP, 2'h0, 14'h0, 1'b0, 1'b0);
        i_lbc_host_model.drive(lbc_pkg::LBC_CMD_RD, 2'h0, 14'h4, 1'b0, 1'b1);
        i_lbc_host_model.drive(lbc_pkg::LBC_CMD_NOP, 2'h0, 14'h0, 1'b0, 1'b1);
        quiet(6);
        cmd(lbc_pkg::LBC_CMD_RD, 2'h0, 14'h0004);
        burst(2'h0, 14'h0004, 3, 2);
        post();
    endtask
    task automatic t_mode();
        cmd(lbc_pkg::LBC_CMD_MODE, 2'h0, 14'h0021);
        repeat (10) @(negedge clk_sys);
        chk(mode_reg_sys, 14'h0032);
        cmd(lbc_pkg::LBC_CMD_RD, 2'h1, 14'h0410);
        wait_open(4'h1);
        cmd(lbc_pkg::LBC_CMD_PRE, 2'h0, 14'h0400);
        wait_open(4'h0);
        i_lbc_host_model.idle(lbc_pkg::PRECHARGE_CYC);
        cmd(lbc_pkg::LBC_CMD_MODE, 2'h0, 14'h0021);
        i_lbc_host_model.idle(lbc_pkg::MODE_LOAD_DELAY_CYC);
        repeat (8) @(negedge clk_sys);
        chk(mode_reg_sys, 14'h0021);
        cmd(lbc_pkg::LBC_CMD_ACT, 2'h2, 14'h0040);
        wait_open(4'h4);
        i_lbc_host_model.idle(lbc_pkg::ACT_TO_ACCESS_CYC);
        cmd(lbc_pkg::LBC_CMD_RD, 2'h2, 14'h0008);
        burst(2'h2, 14'h0008, 2, 1);
        post();
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        i_lbc_host_model.idle(4);
        t_read_basic();
        t_desel();
        t_interleave();
        t_power();
        t_mode();
        results();
    end
endmodule // lbc_bank_cmd_tb
